/* File: rtl/stack_and_interrupt_entry.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE_01: stack grows downward; every push lowers the stack pointer.
// RULE_02: a byte push lowers the stack pointer by exactly one.
// RULE_03: call or interrupt entry storing the return address lowers the pointer by two.
// RULE_04: a byte pop raises the stack pointer by exactly one.
// RULE_05: subroutine or interrupt return raises the pointer by two.
// RULE_06: pointer is two eight-bit io registers, read/write, reset to zero.
// RULE_07: software sets the pointer above the io region before calls or interrupts.
// RULE_08: software masks the unused top bit of a saved program counter.
// RULE_09: logic runs straight on the cpu clock, no division.
// RULE_10: each source has its own vector; taken only with own and global enable.
// RULE_11: vectors at lowest addresses; lower address wins; reset first.
// RULE_12: vector select moves vectors to boot start; boot reset fuse moves reset.
// RULE_13: taking an interrupt clears the global enable.
// RULE_14: global enable set in a handler lets enabled sources nest.
// RULE_15: return from interrupt sets the global enable.
// RULE_16: flag cleared on vectoring; writing one to it also clears it.
// RULE_17: flags stay pending while disabled, then serviced by priority.
// RULE_18: level sources request only while present; never remembered.
// RULE_19: after interrupt return one instruction runs before the next entry.
// RULE_20: status register is not saved; handlers save it themselves.
// RULE_21: disable takes effect at once, even against a same-cycle request.
// RULE_22: after enable the next instruction runs before any entry.
// RULE_23: entry takes four cycles pushing the counter; current instruction finishes first.
// RULE_24: entry from sleep adds four cycles.
// RULE_25: interrupt return takes four cycles, restores counter, pointer plus two.
// RULE_26: push writes at pointer then decrements; pop increments then reads.
module stack_and_interrupt_entry (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [5:0] ioAddr,
  input wire logic ioWrEn,
  input wire logic ioRdEn,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  input wire logic instrBoundary,
  input wire logic [14:0] returnPc,
  input wire logic pushReq,
  input wire logic [7:0] pushData,
  input wire logic popReq,
  output logic [7:0] popData,
  output logic popValid,
  input wire logic callReq,
  input wire logic retReq,
  input wire logic retiReq,
  input wire logic cliReq,
  input wire logic seiReq,
  input wire logic globalEnableWrEn,
  input wire logic globalEnableWrData,
  output logic globalEnable,
  input wire logic sleeping,
  input wire logic [exc_pkg::NUM_FLAG-1:0] flagEvent,
  input wire logic [exc_pkg::NUM_FLAG-1:0] flagEnable,
  input wire logic [exc_pkg::NUM_FLAG-1:0] flagClear,
  output logic [exc_pkg::NUM_FLAG-1:0] flagPending,
  input wire logic [exc_pkg::NUM_LEVEL-1:0] levelReq,
  input wire logic [exc_pkg::NUM_LEVEL-1:0] levelEnable,
  input wire logic vectorSelect,
  input wire logic bootResetFuse,
  output logic [14:0] resetVector,
  output logic [15:0] memAddr,
  output logic [7:0] memWrData,
  output logic memWrEn,
  output logic memRdEn,
  input wire logic [7:0] memRdData,
  output logic busy,
  output logic pcLoad,
  output logic [14:0] pcLoadValue,
  output logic [15:0] stackPointer
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    exc_pkg::ctl_state_t state;
    logic gie;
    logic skip;
    logic [2:0] waitCnt;
    logic isInt;
    logic isReti;
    logic [14:0] pcReg;
    logic [7:0] dataReg;
    logic [7:0] hiReg;
    logic popValid;
    logic [exc_pkg::IDX_W-1:0] idxReg;
    logic strapDone;
    logic bootReset;
    logic [7:0] ioRd;
  } ctl_t;
  ctl_t ctlReg;
  ctl_t ctlNext;

  logic anyOp;
  logic takeOk;
  logic ioSp;
  logic [exc_pkg::IDX_W:0] vecNum;
  logic [14:0] vecBase;
  logic [14:0] vecAddr;

  sp_link_if spLink ();
  irq_link_if irqLink ();

  // ****************************************
  // helpers
  // ****************************************
  stack_pointer_unit spUnit (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .link(spLink)
  );

  irq_arbiter arbiter (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .flagEvent(flagEvent),
    .flagEnable(flagEnable),
    .flagClear(flagClear),
    .levelReq(levelReq),
    .levelEnable(levelEnable),
    .flagPending(flagPending),
    .link(irqLink)
  );

  assign stackPointer = spLink.sp;
  assign spLink.wrData = ioWrData;
  assign spLink.wrLow = ioWrEn && (ioAddr == exc_pkg::SP_LOW_ADDR);
  assign spLink.wrHigh = ioWrEn && (ioAddr == exc_pkg::SP_HIGH_ADDR);
  assign ioSp = spLink.wrLow || spLink.wrHigh;

  // ****************************************
  // take decision
  // ****************************************
  // entries only at an instruction boundary or while sleeping, so multi-cycle work ends first
  assign anyOp = pushReq || popReq || callReq || retReq || retiReq;
  assign takeOk = ce && (ctlReg.state == exc_pkg::S_IDLE) // RULE_23
    && (instrBoundary || sleeping) // RULE_19
    && ctlReg.gie && irqLink.anyReq // RULE_10 RULE_14
    && !cliReq // RULE_21
    && !seiReq && !ctlReg.skip // RULE_22
    && !anyOp;
  assign irqLink.ack = takeOk; // RULE_16
  assign irqLink.ackIdx = irqLink.winner;

  // vector k sits two words above vector k-1, reset at slot zero
  assign vecNum = {1'b0, ctlReg.idxReg} + 4'h1;
  assign vecBase = vectorSelect ? exc_pkg::BOOT_START : exc_pkg::VECTOR_BASE; // RULE_12
  assign vecAddr = vecBase + {10'h000, vecNum, 1'b0}; // RULE_11

  // ****************************************
  // memory and pointer steps
  // ****************************************
  always_comb begin
    memAddr = spLink.sp;
    memWrData = 8'h00;
    memWrEn = 1'b0;
    memRdEn = 1'b0;
    spLink.op = exc_pkg::SP_HOLD;
    case (ctlReg.state)
      exc_pkg::S_PUSH_BYTE: begin
        memWrEn = 1'b1;
        memWrData = ctlReg.dataReg;
        spLink.op = exc_pkg::SP_DEC; // RULE_02 RULE_26
      end
      exc_pkg::S_PUSH_LO: begin
        memWrEn = 1'b1;
        memWrData = ctlReg.pcReg[7:0];
        spLink.op = exc_pkg::SP_DEC; // RULE_03
      end
      exc_pkg::S_PUSH_HI: begin
        memWrEn = 1'b1;
        memWrData = {1'b0, ctlReg.pcReg[14:8]};
        spLink.op = exc_pkg::SP_DEC; // RULE_03
      end
      exc_pkg::S_POP_READ, exc_pkg::S_RET_HI, exc_pkg::S_RET_LO: begin
        memRdEn = 1'b1;
        memAddr = spLink.sp + 16'h0001; // RULE_26
        spLink.op = exc_pkg::SP_INC; // RULE_04 RULE_05
      end
      default: begin
        memRdEn = 1'b0;
      end
    endcase
  end

  // ****************************************
  // control sequence
  // ****************************************
  always_comb begin
    ctlNext = ctlReg;
    ctlNext.popValid = 1'b0;
    // strap sampled once after release, never inside reset
    if (!ctlReg.strapDone) begin
      ctlNext.strapDone = 1'b1;
      ctlNext.bootReset = bootResetFuse; // RULE_12
    end
    if (ioRdEn) begin
      if (ioAddr == exc_pkg::SP_LOW_ADDR) begin
        ctlNext.ioRd = spLink.sp[7:0];
      end else if (ioAddr == exc_pkg::SP_HIGH_ADDR) begin
        ctlNext.ioRd = spLink.sp[15:8];
      end else begin
        ctlNext.ioRd = 8'h00;
      end
    end
    if (globalEnableWrEn) begin
      ctlNext.gie = globalEnableWrData;
    end
    if (seiReq) begin
      ctlNext.gie = 1'b1;
    end
    if (cliReq) begin
      ctlNext.gie = 1'b0; // RULE_21
    end
    if (seiReq) begin
      ctlNext.skip = 1'b1; // RULE_22
    end else if (instrBoundary) begin
      ctlNext.skip = 1'b0;
    end
    case (ctlReg.state)
      exc_pkg::S_IDLE: begin
        if (takeOk) begin
          ctlNext.gie = 1'b0; // RULE_13
          ctlNext.idxReg = irqLink.winner;
          ctlNext.pcReg = returnPc;
          ctlNext.isInt = 1'b1;
          ctlNext.isReti = 1'b0;
          ctlNext.waitCnt = 3'h0;
          ctlNext.state = sleeping ? exc_pkg::S_WAKE : exc_pkg::S_PUSH_LO; // RULE_24
        end else if (retiReq) begin
          ctlNext.isReti = 1'b1;
          ctlNext.state = exc_pkg::S_RET_HI;
        end else if (retReq) begin
          ctlNext.isReti = 1'b0;
          ctlNext.state = exc_pkg::S_RET_HI;
        end else if (callReq) begin
          ctlNext.isInt = 1'b0;
          ctlNext.pcReg = returnPc;
          ctlNext.state = exc_pkg::S_PUSH_LO;
        end else if (pushReq) begin
          ctlNext.dataReg = pushData;
          ctlNext.state = exc_pkg::S_PUSH_BYTE;
        end else if (popReq) begin
          ctlNext.state = exc_pkg::S_POP_READ;
        end
      end
      exc_pkg::S_WAKE: begin
        if (ctlReg.waitCnt == exc_pkg::WAKE_CYCLES - 3'h1) begin
          ctlNext.state = exc_pkg::S_PUSH_LO; // RULE_24
        end else begin
          ctlNext.waitCnt = ctlReg.waitCnt + 3'h1;
        end
      end
      exc_pkg::S_PUSH_BYTE: begin
        ctlNext.state = exc_pkg::S_IDLE;
      end
      exc_pkg::S_POP_READ: begin
        ctlNext.state = exc_pkg::S_POP_CAP;
      end
      exc_pkg::S_POP_CAP: begin
        ctlNext.dataReg = memRdData;
        ctlNext.popValid = 1'b1;
        ctlNext.state = exc_pkg::S_IDLE;
      end
      exc_pkg::S_PUSH_LO: begin
        ctlNext.state = exc_pkg::S_PUSH_HI;
      end
      exc_pkg::S_PUSH_HI: begin
        ctlNext.state = ctlReg.isInt ? exc_pkg::S_ENTRY_WAIT : exc_pkg::S_IDLE;
      end
      exc_pkg::S_ENTRY_WAIT: begin
        ctlNext.pcReg = vecAddr; // RULE_10
        ctlNext.state = exc_pkg::S_ENTRY_VEC;
      end
      exc_pkg::S_ENTRY_VEC: begin
        ctlNext.state = exc_pkg::S_IDLE; // RULE_23
      end
      exc_pkg::S_RET_HI: begin
        ctlNext.state = exc_pkg::S_RET_LO;
      end
      exc_pkg::S_RET_LO: begin
        ctlNext.hiReg = memRdData;
        ctlNext.state = exc_pkg::S_RET_CAP;
      end
      exc_pkg::S_RET_CAP: begin
        // top bit of the saved high byte is unused
        ctlNext.pcReg = {ctlReg.hiReg[6:0], memRdData}; // RULE_08
        ctlNext.state = exc_pkg::S_RET_DONE;
      end
      exc_pkg::S_RET_DONE: begin
        if (ctlReg.isReti) begin
          ctlNext.gie = 1'b1; // RULE_15 RULE_25
        end
        ctlNext.state = exc_pkg::S_IDLE; // RULE_19
      end
      default: begin
        ctlNext.state = exc_pkg::S_IDLE;
      end
    endcase
  end

  // one clock straight from the source; ce freezes everything
  always_ff @(posedge clk or negedge rst_n) begin // RULE_09
    if (!rst_n) begin
      ctlReg <= '0;
    end else if (ce) begin
      ctlReg <= ctlNext;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign ioRdData = ctlReg.ioRd;
  assign popData = ctlReg.dataReg;
  assign popValid = ctlReg.popValid;
  assign globalEnable = ctlReg.gie;
  assign busy = ctlReg.state != exc_pkg::S_IDLE;
  assign pcLoad = (ctlReg.state == exc_pkg::S_ENTRY_VEC) || (ctlReg.state == exc_pkg::S_RET_DONE);
  assign pcLoadValue = ctlReg.pcReg;
  assign resetVector = ctlReg.bootReset ? exc_pkg::BOOT_START : exc_pkg::RESET_VECTOR; // RULE_12

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  gieClear_a: assert property (takeOk |=> !ctlReg.gie)
    else $error("global enable left set on entry"); // RULE_13
  entryTime_a: assert property ((takeOk && !sleeping) ##1 ce [*3] |=> pcLoad)
    else $error("entry not four cycles"); // RULE_23
  wakeTime_a: assert property ((takeOk && sleeping) ##1 ce [*7] |=> pcLoad)
    else $error("wake entry not eight cycles"); // RULE_24
  retiTime_a: assert property ((ctlReg.state == exc_pkg::S_IDLE && ce && retiReq)
    ##1 ce [*3] |=> (pcLoad && ctlReg.isReti)) else $error("return not four cycles"); // RULE_25
  retiGie_a: assert property ((ce && pcLoad && ctlReg.isReti) |=> ctlReg.gie)
    else $error("return left enable clear"); // RULE_15
  cliBlock_a: assert property (cliReq |-> !irqLink.ack)
    else $error("entry beside disable"); // RULE_21
  seiSkip_a: assert property ((ce && seiReq) |=> (ctlReg.skip && !takeOk))
    else $error("entry right after enable"); // RULE_22
  pushOrder_a: assert property ((ce && memWrEn && !ioSp)
    |=> stackPointer == $past(memAddr) - 16'h0001) else $error("push order wrong"); // RULE_26
  popOrder_a: assert property ((ce && memRdEn && !ioSp)
    |=> stackPointer == $past(memAddr)) else $error("pop order wrong"); // RULE_26
  callTwo_a: assert property ((ctlReg.state == exc_pkg::S_PUSH_LO && ce && !ioSp)
    ##1 (ce && !ioSp) |=> stackPointer == $past(stackPointer, 2) - 16'h0002)
    else $error("address push not minus two"); // RULE_03
  retTwo_a: assert property ((ctlReg.state == exc_pkg::S_RET_HI && ce && !ioSp)
    ##1 (ce && !ioSp) |=> stackPointer == $past(stackPointer, 2) + 16'h0002)
    else $error("address pop not plus two"); // RULE_05
endmodule
`default_nettype wire

/* File: rtl/exc_pkg.sv */
`default_nettype none
package exc_pkg;
  // ****************************************
  // io addresses and reset values
  // ****************************************
  localparam logic [5:0] SP_LOW_ADDR = 6'h3D;
  localparam logic [5:0] SP_HIGH_ADDR = 6'h3E;
  localparam logic [7:0] SP_RESET = 8'h00;
  // ****************************************
  // sources and vectors
  // ****************************************
  localparam int NUM_FLAG = 4;
  localparam int NUM_LEVEL = 4;
  localparam int NUM_SRC = NUM_FLAG + NUM_LEVEL;
  localparam int IDX_W = 3;
  localparam logic [14:0] RESET_VECTOR = 15'h0000;
  localparam logic [14:0] VECTOR_BASE = 15'h0000;
  localparam logic [14:0] BOOT_START = 15'h7000;
  localparam logic [2:0] WAKE_CYCLES = 3'h4;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SP_HOLD = 2'b00,
    SP_DEC = 2'b01,
    SP_INC = 2'b10
  } sp_op_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_WAKE = 4'b0001,
    S_PUSH_BYTE = 4'b0010,
    S_POP_READ = 4'b0011,
    S_POP_CAP = 4'b0100,
    S_PUSH_LO = 4'b0101,
    S_PUSH_HI = 4'b0110,
    S_ENTRY_WAIT = 4'b0111,
    S_ENTRY_VEC = 4'b1000,
    S_RET_HI = 4'b1001,
    S_RET_LO = 4'b1010,
    S_RET_CAP = 4'b1011,
    S_RET_DONE = 4'b1100
  } ctl_state_t;
endpackage
`default_nettype wire

/* File: rtl/exc_links.sv */
`timescale 1ns/1ps
`default_nettype none
interface sp_link_if;
  exc_pkg::sp_op_t op;
  logic wrLow;
  logic wrHigh;
  logic [7:0] wrData;
  logic [15:0] sp;
  modport ctrl (output op, output wrLow, output wrHigh, output wrData, input sp);
  modport unit (input op, input wrLow, input wrHigh, input wrData, output sp);
endinterface

interface irq_link_if;
  logic anyReq;
  logic [exc_pkg::IDX_W-1:0] winner;
  logic ack;
  logic [exc_pkg::IDX_W-1:0] ackIdx;
  modport ctrl (input anyReq, input winner, output ack, output ackIdx);
  modport arb (output anyReq, output winner, input ack, input ackIdx);
endinterface
`default_nettype wire

/* File: rtl/stack_pointer_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module stack_pointer_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  sp_link_if.unit link
);
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } sp_state_t;
  sp_state_t spReg;
  sp_state_t spNext;

  // ****************************************
  // pointer update
  // ****************************************
  // io write wins over a stack step in the same cycle
  always_comb begin
    spNext = spReg;
    if (link.wrLow || link.wrHigh) begin
      if (link.wrLow) spNext.low = link.wrData;
      if (link.wrHigh) spNext.high = link.wrData;
    end else if (link.op == exc_pkg::SP_DEC) begin
      spNext = sp_state_t'({spReg.high, spReg.low} - 16'h0001); // RULE_01
    end else if (link.op == exc_pkg::SP_INC) begin
      spNext = sp_state_t'({spReg.high, spReg.low} + 16'h0001); // RULE_04
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spReg <= '{high: exc_pkg::SP_RESET, low: exc_pkg::SP_RESET}; // RULE_06
    end else if (ce) begin
      spReg <= spNext;
    end
  end

  assign link.sp = {spReg.high, spReg.low};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  spDecOne_a: assert property ((ce && link.op == exc_pkg::SP_DEC && !link.wrLow && !link.wrHigh)
    |=> link.sp == $past(link.sp) - 16'h0001) else $error("push step not minus one"); // RULE_02
  spIncOne_a: assert property ((ce && link.op == exc_pkg::SP_INC && !link.wrLow && !link.wrHigh)
    |=> link.sp == $past(link.sp) + 16'h0001) else $error("pop step not plus one"); // RULE_04
endmodule
`default_nettype wire

/* File: rtl/irq_arbiter.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_arbiter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [exc_pkg::NUM_FLAG-1:0] flagEvent,
  input wire logic [exc_pkg::NUM_FLAG-1:0] flagEnable,
  input wire logic [exc_pkg::NUM_FLAG-1:0] flagClear,
  input wire logic [exc_pkg::NUM_LEVEL-1:0] levelReq,
  input wire logic [exc_pkg::NUM_LEVEL-1:0] levelEnable,
  output logic [exc_pkg::NUM_FLAG-1:0] flagPending,
  irq_link_if.arb link
);
  typedef struct packed {
    logic [exc_pkg::NUM_FLAG-1:0] flags;
  } arb_state_t;
  arb_state_t arbReg;
  arb_state_t arbNext;
  logic [exc_pkg::NUM_FLAG-1:0] ackHit;
  logic [exc_pkg::NUM_SRC-1:0] req;

  // ****************************************
  // flags
  // ****************************************
  for (genvar g = 0; g < exc_pkg::NUM_FLAG; g++) begin : g_flag
    assign ackHit[g] = link.ack && (int'(link.ackIdx) == g);
  end

  // new event beats a clear in the same cycle
  always_comb begin
    arbNext = arbReg;
    arbNext.flags = (arbReg.flags & ~(flagClear | ackHit)) | flagEvent; // RULE_16
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arbReg <= '0;
    end else if (ce) begin
      arbReg <= arbNext;
    end
  end

  // ****************************************
  // priority
  // ****************************************
  // level sources are never latched
  assign req = {levelReq & levelEnable, arbReg.flags & flagEnable}; // RULE_18
  always_comb begin
    link.winner = '0;
    link.anyReq = 1'b0;
    for (int i = exc_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        link.winner = i[exc_pkg::IDX_W-1:0]; // RULE_11
        link.anyReq = 1'b1;
      end
    end
  end

  assign flagPending = arbReg.flags;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  flagKept_a: assert property ((ce && arbReg.flags[0] && !ackHit[0] && !flagClear[0])
    |=> arbReg.flags[0]) else $error("pending flag lost"); // RULE_17
  flagAckClr_a: assert property ((ce && ackHit[1] && !flagEvent[1])
    |=> !arbReg.flags[1]) else $error("flag not cleared on vectoring"); // RULE_16
endmodule
`default_nettype wire

/* File: test/stack_memory.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// data memory behind the stack port
// ****************************************
module stack_memory (
  input wire logic clk,
  input wire logic [15:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [7:0] rdData
);
  logic [7:0] cells [0:65535];
  initial rdData = 8'h00;
  always @(posedge clk) begin
    if (wrEn) begin
      cells[addr] <= wrData;
    end
    // not a read: invert so stale data never looks valid
    rdData <= rdEn ? cells[addr] : ~rdData;
  end
endmodule
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rst_n, ce, ioWrEn, ioRdEn, instrBoundary, pushReq, popReq, callReq, retReq;
  logic retiReq, cliReq, seiReq, globalEnableWrEn, globalEnableWrData, sleeping;
  logic vectorSelect, bootResetFuse, popValid, globalEnable, memWrEn, memRdEn, busy, pcLoad;
  logic [5:0] ioAddr;
  logic [7:0] ioWrData, pushData, ioRdData, popData, memWrData, memRdData;
  logic [14:0] returnPc, resetVector, pcLoadValue, pc;
  logic [15:0] memAddr, stackPointer, sp;
  logic [3:0] flagEvent, flagEnable, flagClear, flagPending, levelReq, levelEnable;
  logic [7:0] q [4];
  logic [31:0] seed;
  int errCount, checks, n;
  stack_and_interrupt_entry dut (.clk, .rst_n, .ce, .ioAddr, .ioWrEn, .ioRdEn, .ioWrData,
    .ioRdData, .instrBoundary, .returnPc, .pushReq, .pushData, .popReq, .popData, .popValid,
    .callReq, .retReq, .retiReq, .cliReq, .seiReq, .globalEnableWrEn, .globalEnableWrData,
    .globalEnable, .sleeping, .flagEvent, .flagEnable, .flagClear, .flagPending, .levelReq,
    .levelEnable, .vectorSelect, .bootResetFuse, .resetVector, .memAddr, .memWrData, .memWrEn,
    .memRdEn, .memRdData, .busy, .pcLoad, .pcLoadValue, .stackPointer);
  stack_memory mem (.clk, .addr(memAddr), .wrData(memWrData), .wrEn(memWrEn), .rdEn(memRdEn),
    .rdData(memRdData));
  always #12.5 clk = ~clk;
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [14:0] vec(input int idx, input logic sel);
    return (sel ? exc_pkg::BOOT_START : exc_pkg::VECTOR_BASE) + 15'(2 * (idx + 1));
  endfunction
  task conclude;
    $display("errors %0d checks %0d", errCount, checks);
    if (errCount == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task fail;
    errCount++;
    $display("CHECK FAILED at %0t: wait timed out", $time);
    conclude;
  endtask
  task chk(input logic [15:0] a, input logic [15:0] e, input string m);
    checks++;
    if (a !== e) begin
      errCount++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, a, e);
    end
  endtask
  task cyc;
    @(posedge clk);
    #1;
  endtask
  task op(input logic [4:0] r);
    {retiReq, retReq, callReq, pushReq, popReq} = r;
    cyc;
    {retiReq, retReq, callReq, pushReq, popReq} = 5'h00;
  endtask
  task waitIdle;
    for (int k = 0; busy !== 1'b0; k++) begin
      if (k > 40) fail;
      cyc;
    end
  endtask
  task take;
    for (n = 1; pcLoad !== 1'b1; n++) begin
      if (n > 30) fail;
      cyc;
    end
  endtask
  task quiet(input int c);
    int h;
    h = 0;
    repeat (c) begin
      if (pcLoad !== 1'b0) h++;
      cyc;
    end
    chk(16'(h), 16'h0000, "unexpected entry");
  endtask
  task ioW(input logic [5:0] a, input logic [7:0] d);
    ioAddr = a;
    ioWrData = d;
    ioWrEn = 1;
    cyc;
    ioWrEn = 0;
    cyc;
  endtask
  task ioR(input logic [5:0] a, input logic [7:0] e);
    ioAddr = a;
    ioRdEn = 1;
    cyc;
    ioRdEn = 0;
    chk(16'(ioRdData), 16'(e), "io read");
    cyc;
  endtask
  task gieW(input logic b);
    globalEnableWrData = b;
    globalEnableWrEn = 1;
    cyc;
    globalEnableWrEn = 0;
  endtask
  task flagEv(input logic [3:0] m);
    flagEvent = m;
    cyc;
    flagEvent = 4'h0;
  endtask
  task bnd;
    instrBoundary = 1;
    cyc;
    instrBoundary = 0;
  endtask
  // one entry from an instruction boundary, awake
  task enter(input logic [14:0] p, input logic [14:0] v);
    returnPc = p;
    bnd;
    take;
    chk(16'(pcLoadValue), 16'(v), "vector");
    chk(16'(n), 16'h0004, "entry cycles");
    waitIdle;
    sp = sp - 16'h0002;
    chk(stackPointer, sp, "sp after entry");
  endtask
  task return_from_interrupt(input logic [14:0] p);
    op(5'h10);
    take;
    chk(16'(pcLoadValue), 16'(p), "return pc");
    chk(16'(n), 16'h0004, "return cycles");
    waitIdle;
    cyc;
    sp = sp + 16'h0002;
    chk(stackPointer, sp, "sp after return");
    chk(16'(globalEnable), 16'h0001, "enable after return");
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {clk, rst_n, ioWrEn, ioRdEn, instrBoundary, pushReq, popReq, callReq, retReq} = 9'h000;
    {retiReq, cliReq, seiReq, globalEnableWrEn, globalEnableWrData, sleeping} = 6'h00;
    {ioAddr, ioWrData, pushData, returnPc} = 37'h0;
    {flagEvent, flagClear, levelReq, levelEnable} = 16'h0000;
    ce = 1;
    vectorSelect = 0;
    bootResetFuse = 1;
    flagEnable = 4'hF;
    errCount = 0;
    checks = 0;
    seed = 32'h6A5CEAD6;
    repeat (20) @(posedge clk);
    #1 rst_n = 1;
    cyc;
    cyc;
    chk(16'(resetVector), 16'(exc_pkg::BOOT_START), "reset vector");
    ioR(exc_pkg::SP_LOW_ADDR, 8'h00);
    ioR(exc_pkg::SP_HIGH_ADDR, 8'h00);
    ioR(6'h10, 8'h00);
    ioW(exc_pkg::SP_LOW_ADDR, 8'hFF);
    ioW(exc_pkg::SP_HIGH_ADDR, 8'h10);
    sp = 16'h10FF;
    chk(stackPointer, sp, "sp written");
    ioR(exc_pkg::SP_HIGH_ADDR, 8'h10);
    for (int i = 0; i < 4; i++) begin
      q[i] = 8'($random(seed));
      pushData = q[i];
      op(5'h02);
      waitIdle;
      chk(16'(mem.cells[sp]), 16'(q[i]), "pushed byte");
      sp = sp - 16'h0001;
      chk(stackPointer, sp, "sp after push");
    end
    for (int i = 3; i >= 0; i--) begin
      op(5'h01);
      for (n = 0; popValid !== 1'b1; n++) begin
        if (n > 10) fail;
        cyc;
      end
      chk(16'(popData), 16'(q[i]), "popped byte");
      waitIdle;
      sp = sp + 16'h0001;
      chk(stackPointer, sp, "sp after pop");
    end
    pc = 15'($random(seed));
    returnPc = pc;
    op(5'h04);
    waitIdle;
    chk(16'(mem.cells[sp]), 16'(pc[7:0]), "call low byte");
    chk(16'(mem.cells[sp - 16'h0001]), 16'({1'b0, pc[14:8]}), "call high byte");
    sp = sp - 16'h0002;
    chk(stackPointer, sp, "sp after call");
    op(5'h08);
    take;
    chk(16'(pcLoadValue), 16'(pc), "ret pc");
    waitIdle;
    sp = sp + 16'h0002;
    chk(stackPointer, sp, "sp after ret");
    // entry, nesting, return
    gieW(1);
    flagEv(4'b0100);
    enter(15'h0123, vec(2, 1'b0));
    chk(16'(globalEnable), 16'h0000, "enable on entry");
    chk(16'(flagPending), 16'h0000, "flag on entry");
    gieW(1);
    flagEv(4'b0001);
    enter(15'h0456, vec(0, 1'b0));
    return_from_interrupt(15'h0456);
    return_from_interrupt(15'h0123);
    // pending while disabled, then priority
    flagEnable = 4'h0;
    flagEv(4'b1010);
    bnd;
    quiet(8);
    chk(16'(flagPending), 16'h000A, "pending kept");
    flagEnable = 4'hF;
    enter(15'h0200, vec(1, 1'b0));
    chk(16'(flagPending), 16'h0008, "lower kept");
    flagClear = 4'b1000;
    cyc;
    flagClear = 4'h0;
    cyc;
    chk(16'(flagPending), 16'h0000, "write one clears");
    // disable and enable beside a boundary
    gieW(1);
    flagEv(4'b0001);
    cliReq = 1;
    bnd;
    cliReq = 0;
    quiet(8);
    chk(16'(globalEnable), 16'h0000, "cleared at once");
    seiReq = 1;
    bnd;
    seiReq = 0;
    quiet(3);
    bnd;
    quiet(3);
    enter(15'h0300, vec(0, 1'b0));
    // level requests
    levelEnable = 4'b0011;
    levelReq = 4'b0001;
    cyc;
    levelReq = 4'h0;
    gieW(1);
    bnd;
    quiet(8);
    vectorSelect = 1;
    levelReq = 4'b0010;
    enter(15'h0400, vec(5, 1'b1));
    levelReq = 4'h0;
    vectorSelect = 0;
    // wake from sleep: no boundary needed, four extra cycles
    gieW(1);
    flagEv(4'b0100);
    returnPc = 15'h0500;
    sleeping = 1;
    cyc;
    sleeping = 0;
    take;
    chk(16'(pcLoadValue), 16'(vec(2, 1'b0)), "wake vector");
    chk(16'(n), 16'h0008, "wake entry cycles");
    waitIdle;
    sp = sp - 16'h0002;
    chk(stackPointer, sp, "sp after wake entry");
    // second reset in mid-run, fuse left open
    bootResetFuse = 0;
    rst_n = 0;
    cyc;
    rst_n = 1;
    cyc;
    cyc;
    chk(16'(resetVector), 16'(exc_pkg::RESET_VECTOR), "reset vector open fuse");
    chk(stackPointer, {exc_pkg::SP_RESET, exc_pkg::SP_RESET}, "sp after reset");
    conclude;
  end
endmodule
`default_nettype wire
